// ### design/tau_timer_consts.vh
// Purpose: constants of the timer array channel unit
// Assumes: 32-bit APB, one aligned word per register
// Notes:   byte addresses, field positions, codes
`ifndef TAU_TIMER_CONSTS_VH
`define TAU_TIMER_CONSTS_VH
// ****************************************
// register byte addresses
// ****************************************
`define TAU_A_RST   12'h000
`define TAU_A_GATE  12'h004
`define TAU_A_PRE   12'h008
`define TAU_A_OE    12'h00C
`define TAU_A_OUT   12'h010
`define TAU_A_START 12'h014
`define TAU_A_STOP  12'h018
`define TAU_A_STAT  12'h01C
`define TAU_A_MASK  12'h020
`define TAU_A_RUN   12'h024
// channel regions: base + 4 * channel
`define TAU_R_MODE  7'h02
`define TAU_R_DATA  7'h03
`define TAU_R_CNT   7'h04
// ****************************************
// reset values and write masks
// ****************************************
`define TAU_RST_INIT  1'b1
`define TAU_GATE_INIT 1'b0
`define TAU_MODE_INIT 16'h0000
`define TAU_MODE_WM   16'hD7CF
`define TAU_MODE_WMM  16'hDFCF
// ****************************************
// mode register fields
// ****************************************
`define TAU_F_CKS_HI 15
`define TAU_F_CKS_LO 14
`define TAU_F_CCS    12
`define TAU_F_MST    11
`define TAU_F_STS_HI 10
`define TAU_F_STS_LO 8
`define TAU_F_CIS_HI 7
`define TAU_F_CIS_LO 6
`define TAU_F_MD_HI  3
`define TAU_F_MD_LO  1
`define TAU_F_MD0    0
// ****************************************
// codes
// ****************************************
`define TAU_MD_INT  3'b000
`define TAU_MD_CAP  3'b010
`define TAU_MD_EVT  3'b011
`define TAU_MD_ONE  3'b100
`define TAU_MD_CONE 3'b110
`define TAU_STS_PIN  3'b001
`define TAU_STS_BOTH 3'b010
`define TAU_STS_MST  3'b100
`endif

// ### design/tau_timer_array.v
// Purpose: multi-channel timer unit with APB registers
// Assumes: SYS_CLK 125 MHz, RESETN async active low
// Notes:   timer pins pass a three-stage synchroniser
// Summary of operation
// - reset bit at one holds unit reset
// - clock gate zero freezes the whole unit
// - prescaler field divides by two to power
// - op clock select 00=a 01=c 10=b 11=d
// - count source: operation clock or pin edge
// - trigger: software, edge, both edges, master
// - edge field: fall, rise, low, high width
// - mode field picks five modes, others idle
// - start bit gives start interrupt and toggle in interval and capture
// - one-count retrigger only with start bit
// - capture one-count ignores start bit, retrigger
// - interval irq every data plus one ticks
// - output disabled: software owns output bit
// - output enabled: timer owns output bit
// - enable register low byte, upper reads zero
// - master bit on even channels, not zero
// - master bit set: channel drives slaves
`timescale 1ns/1ps
`default_nettype none
`include "tau_timer_consts.vh"
module tau_timer_array #(
	parameter NUM_CH = 8
) (
	input  wire              SYS_CLK,      // system clock
	input  wire              RESETN,       // async reset, low
	input  wire              PSEL,         // apb select
	input  wire              PENABLE,      // apb enable
	input  wire              PWRITE,       // apb direction
	input  wire [11:0]       PADDR,        // apb byte address
	input  wire [31:0]       PWDATA,       // apb write data
	output reg  [31:0]       PRDATA,       // apb read data
	output reg               PREADY,       // apb ready
	output reg               PSLVERR,      // apb error
	input  wire [NUM_CH-1:0] TIMER_IN,     // timer input pins
	output wire [NUM_CH-1:0] TIMER_OUT,    // timer output pins
	output wire [NUM_CH-1:0] TIMER_OUT_EN, // timer owns pin
	output reg               IRQ           // level interrupt
);
	// ****************************************
	// functions
	// ****************************************
	function pre_tick;
		input [15:0] c;
		input [3:0]  p;
		reg   [15:0] m;
		begin
			m = (16'h0001 << p) - 16'h0001;
			pre_tick = ((c & m) == m);
		end
	endfunction

	function sel_clk;
		input [1:0] s;
		input [3:0] t;
		begin
			case (s)
			2'b00: sel_clk = t[0];
			2'b01: sel_clk = t[2];
			2'b10: sel_clk = t[1];
			default: sel_clk = t[3];
			endcase
		end
	endfunction

	// ****************************************
	// bus slave
	// ****************************************
	reg               rst_reg;
	reg               gate_reg;
	reg  [15:0]       pre_reg;
	reg  [15:0]       pcnt_reg;
	reg  [NUM_CH-1:0] oe_reg;
	reg  [NUM_CH-1:0] stat_reg;
	reg  [NUM_CH-1:0] mask_reg;
	wire [NUM_CH-1:0] ch_irq;
	wire [NUM_CH-1:0] ch_run;
	wire [NUM_CH-1:0] ch_out;
	wire [NUM_CH-1:0] chain;
	wire [16*NUM_CH-1:0] mode_f;
	wire [16*NUM_CH-1:0] data_f;
	wire [16*NUM_CH-1:0] cnt_f;
	wire [3:0]        tick;
	reg  [31:0]       rd;
	reg               hit;
	wire [2:0]        ci = PADDR[4:2];
	wire [6:0]        cr = {4'h0, ci} << 4;
	wire              ch_ok = ({1'b0, ci} < NUM_CH) &&
	                          (PADDR[1:0] == 2'b00);
	wire              wr = PSEL & PENABLE & PWRITE & PREADY;
	wire              u_on = ~rst_reg & gate_reg;

	// read mux; unmapped addresses answer with an error
	always @* begin
		rd = 32'h0000_0000;
		hit = 1'b1;
		case (PADDR)
		`TAU_A_RST:   rd[0] = rst_reg;
		`TAU_A_GATE:  rd[0] = gate_reg;
		`TAU_A_PRE:   rd[15:0] = pre_reg;
		`TAU_A_OE:    rd[NUM_CH-1:0] = oe_reg;
		`TAU_A_OUT:   rd[NUM_CH-1:0] = ch_out;
		`TAU_A_START: rd = 32'h0000_0000;
		`TAU_A_STOP:  rd = 32'h0000_0000;
		`TAU_A_STAT:  rd[NUM_CH-1:0] = stat_reg;
		`TAU_A_MASK:  rd[NUM_CH-1:0] = mask_reg;
		`TAU_A_RUN:   rd[NUM_CH-1:0] = ch_run;
		default: begin
			if (ch_ok && PADDR[11:5] == `TAU_R_MODE)
				rd[15:0] = mode_f[cr +: 16];
			else if (ch_ok && PADDR[11:5] == `TAU_R_DATA)
				rd[15:0] = data_f[cr +: 16];
			else if (ch_ok && PADDR[11:5] == `TAU_R_CNT)
				rd[15:0] = cnt_f[cr +: 16];
			else
				hit = 1'b0;
		end
		endcase
	end

	// answer in the first access cycle; data registered at setup
	always @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL & ~PENABLE;
			if (PSEL & ~PENABLE) begin
				PRDATA <= PWRITE ? 32'h0000_0000 : rd;
				PSLVERR <= ~hit;
			end
		end
	end

	// ****************************************
	// unit control, prescaler, interrupts
	// ****************************************
	always @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_reg <= `TAU_RST_INIT;
			gate_reg <= `TAU_GATE_INIT;
		end else begin
			if (wr && PADDR == `TAU_A_RST)
				rst_reg <= PWDATA[0];
			if (wr && PADDR == `TAU_A_GATE)
				gate_reg <= PWDATA[0];
		end
	end

	always @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			pre_reg <= 16'h0000;
			pcnt_reg <= 16'h0000;
			oe_reg <= {NUM_CH{1'b0}};
			stat_reg <= {NUM_CH{1'b0}};
			mask_reg <= {NUM_CH{1'b0}};
			IRQ <= 1'b0;
		end else if (rst_reg) begin
			pre_reg <= 16'h0000;
			pcnt_reg <= 16'h0000;
			oe_reg <= {NUM_CH{1'b0}};
			stat_reg <= {NUM_CH{1'b0}};
			mask_reg <= {NUM_CH{1'b0}};
			IRQ <= 1'b0;
		end else if (gate_reg) begin
			pcnt_reg <= pcnt_reg + 16'h0001;
			if (wr && PADDR == `TAU_A_PRE)
				pre_reg <= PWDATA[15:0];
			if (wr && PADDR == `TAU_A_OE)
				oe_reg <= PWDATA[NUM_CH-1:0];
			if (wr && PADDR == `TAU_A_MASK)
				mask_reg <= PWDATA[NUM_CH-1:0];
			// an event in the clearing cycle survives
			if (wr && PADDR == `TAU_A_STAT)
				stat_reg <= (stat_reg & ~PWDATA[NUM_CH-1:0]) |
				            ch_irq;
			else
				stat_reg <= stat_reg | ch_irq;
			IRQ <= |((stat_reg | ch_irq) & mask_reg);
		end
	end

	genvar k;
	generate
		for (k = 0; k < 4; k = k + 1) begin : g_pre
			assign tick[k] = pre_tick(pcnt_reg, pre_reg[4*k +: 4]);
		end
	endgenerate

	assign TIMER_OUT_EN = oe_reg;
	assign TIMER_OUT = ch_out;

	// ****************************************
	// channels
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < NUM_CH; i = i + 1) begin : g_ch
			reg  [15:0] mode_reg;
			reg  [15:0] data_reg;
			reg  [15:0] cnt_reg;
			reg         run_reg;
			reg         out_reg;
			reg         irq_reg;
			reg         s1_reg;
			reg         s2_reg;
			reg         s3_reg;
			reg         lvl_reg;
			reg         old_reg;
			wire [2:0]  md = mode_reg[`TAU_F_MD_HI:`TAU_F_MD_LO];
			wire [2:0]  sts = mode_reg[`TAU_F_STS_HI:`TAU_F_STS_LO];
			wire [1:0]  cis = mode_reg[`TAU_F_CIS_HI:`TAU_F_CIS_LO];
			wire        md0 = mode_reg[`TAU_F_MD0];
			wire        rise = lvl_reg & ~old_reg;
			wire        fall = ~lvl_reg & old_reg;
			wire        st_e;
			wire        cp_e;
			wire        slave_in;
			wire        ctick;
			wire        start;
			wire        cap;
			wire        legal;
			wire        retrig;
			wire        go;
			wire        last = (cnt_reg == 16'h0000);
			wire [15:0] wmask = (i != 0 && i % 2 == 0) ?
			                    `TAU_MODE_WMM : `TAU_MODE_WM;

			// start and capture edges per edge field
			assign st_e = cis[1] ? (cis[0] ? rise : fall) :
			              (cis[0] ? rise : fall);
			assign cp_e = cis[1] ? (cis[0] ? fall : rise) :
			              st_e;
			if (i == 0) begin : g_m0
				assign slave_in = 1'b0;
			end else begin : g_mn
				assign slave_in = chain[i-1];
			end
			// nearest lower master passes its interrupt upward
			if (i == 0) begin : g_c0
				assign chain[i] = irq_reg;
			end else begin : g_cn
				assign chain[i] = mode_reg[`TAU_F_MST] ? irq_reg :
				                  chain[i-1];
			end

			assign ctick = mode_reg[`TAU_F_CCS] ? st_e :
			        sel_clk(mode_reg[`TAU_F_CKS_HI:`TAU_F_CKS_LO],
			                tick);
			assign start = (wr && PADDR == `TAU_A_START &&
			                PWDATA[i]) ||
			               (sts == `TAU_STS_PIN && st_e) ||
			               (sts == `TAU_STS_BOTH && st_e) ||
			               (sts == `TAU_STS_MST && slave_in);
			assign cap = (sts == `TAU_STS_PIN && st_e) ||
			             (sts == `TAU_STS_BOTH && cp_e);
			assign legal = md == `TAU_MD_INT || md == `TAU_MD_CAP ||
			               md == `TAU_MD_EVT || md == `TAU_MD_ONE ||
			               md == `TAU_MD_CONE;
			assign retrig = run_reg && md == `TAU_MD_ONE &&
			                md0;
			assign go = legal && start &&
			            (!run_reg || retrig);

			// synchroniser: level accepted once stages 2 and 3 agree
			always @(posedge SYS_CLK or negedge RESETN) begin
				if (!RESETN) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					lvl_reg <= 1'b0;
					old_reg <= 1'b0;
				end else begin
					s1_reg <= TIMER_IN[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg)
						lvl_reg <= s3_reg;
					old_reg <= lvl_reg;
				end
			end

			always @(posedge SYS_CLK or negedge RESETN) begin
				if (!RESETN) begin
					mode_reg <= `TAU_MODE_INIT;
					data_reg <= 16'h0000;
					cnt_reg <= 16'h0000;
					run_reg <= 1'b0;
					out_reg <= 1'b0;
					irq_reg <= 1'b0;
				end else if (!u_on) begin
					irq_reg <= 1'b0;
					if (rst_reg) begin
						mode_reg <= `TAU_MODE_INIT;
						data_reg <= 16'h0000;
						cnt_reg <= 16'h0000;
						run_reg <= 1'b0;
						out_reg <= 1'b0;
					end
				end else begin
					irq_reg <= 1'b0;
					if (wr && PADDR[11:5] == `TAU_R_MODE && ci == i)
						mode_reg <= PWDATA[15:0] & wmask;
					if (wr && PADDR[11:5] == `TAU_R_DATA && ci == i)
						data_reg <= PWDATA[15:0];
					if (wr && PADDR == `TAU_A_OUT && !oe_reg[i])
						out_reg <= PWDATA[i];
					if (wr && PADDR == `TAU_A_STOP && PWDATA[i]) begin
						run_reg <= 1'b0;
					end else if (go) begin
						run_reg <= 1'b1;
						case (md)
						`TAU_MD_CAP, `TAU_MD_CONE: cnt_reg <= 16'h0000;
						default: cnt_reg <= data_reg;
						endcase
						// start notice only where the mode allows it
						if ((md == `TAU_MD_INT || md == `TAU_MD_CAP) &&
						    md0) begin
							irq_reg <= 1'b1;
							if (oe_reg[i])
								out_reg <= ~out_reg;
						end
						if (md == `TAU_MD_ONE) begin
							irq_reg <= retrig;
							if (oe_reg[i])
								out_reg <= 1'b1;
						end
					end else if (run_reg) begin
						case (md)
						`TAU_MD_INT, `TAU_MD_EVT: if (ctick) begin
							if (last) begin
								cnt_reg <= data_reg;
								irq_reg <= 1'b1;
								if (oe_reg[i] && md == `TAU_MD_INT)
									out_reg <= ~out_reg;
							end else
								cnt_reg <= cnt_reg - 16'h0001;
						end
						`TAU_MD_ONE: if (ctick) begin
							if (last) begin
								irq_reg <= 1'b1;
								run_reg <= 1'b0;
								if (oe_reg[i])
									out_reg <= 1'b0;
							end else
								cnt_reg <= cnt_reg - 16'h0001;
						end
						`TAU_MD_CAP: if (cap) begin
							data_reg <= cnt_reg;
							cnt_reg <= 16'h0000;
							irq_reg <= 1'b1;
						end else if (ctick)
							cnt_reg <= cnt_reg + 16'h0001;
						`TAU_MD_CONE: if (cap) begin
							data_reg <= cnt_reg;
							irq_reg <= 1'b1;
							run_reg <= 1'b0;
						end else if (ctick)
							cnt_reg <= cnt_reg + 16'h0001;
						default: run_reg <= 1'b0;
						endcase
					end
				end
			end

			assign ch_irq[i] = irq_reg;
			assign ch_run[i] = run_reg;
			assign ch_out[i] = out_reg;
			assign mode_f[16*i +: 16] = mode_reg;
			assign data_f[16*i +: 16] = data_reg;
			assign cnt_f[16*i +: 16] = cnt_reg;
		end
	endgenerate
endmodule // tau_timer_array
`default_nettype wire

// ### tb/tau_chk_sva.sv
// Purpose: bus and pin checks for the timer unit
// Assumes: one wait-free APB access, unit regs as in the consts
// Notes:   reset and gate bits shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
`include "tau_timer_consts.vh"
module tau_chk #(
	parameter NUM_CH = 8
) (
	input wire logic              SYS_CLK,      // clock
	input wire logic              RESETN,       // reset, low
	input wire logic              PSEL,         // select
	input wire logic              PENABLE,      // enable
	input wire logic              PWRITE,       // direction
	input wire logic [11:0]       PADDR,        // address
	input wire logic [31:0]       PWDATA,       // write data
	input wire logic [31:0]       PRDATA,       // read data
	input wire logic              PREADY,       // ready
	input wire logic              PSLVERR,      // error
	input wire logic [NUM_CH-1:0] TIMER_OUT,    // pin levels
	input wire logic [NUM_CH-1:0] TIMER_OUT_EN, // pin owner
	input wire logic              IRQ           // interrupt
);
	logic rst_reg;
	logic gate_reg;
	wire  wr_done = PSEL && PENABLE && PREADY && PWRITE;
	wire  unit_on = !rst_reg && gate_reg;
	wire  unit_frz = !rst_reg && !gate_reg;
	wire  mapped = PADDR[1:0] == 2'h0 && (PADDR <= 12'h024 ||
		(PADDR >= 12'h040 && PADDR < 12'h0A0 && PADDR[4:2] < NUM_CH));
	// ****************************************
	// shadow of unit enables; bus is the only way in
	// ****************************************
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_reg  <= 1'b1;
			gate_reg <= 1'b0;
		end else if (wr_done && PADDR == `TAU_A_RST) begin
			rst_reg <= PWDATA[0];
		end else if (wr_done && PADDR == `TAU_A_GATE) begin
			gate_reg <= PWDATA[0];
		end
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);
	property p_ready;
		PSEL && !PENABLE |=> PREADY;
	endproperty
	a_ready: assert property (p_ready) else $error("ready late");
	property p_pulse;
		PREADY |=> !PREADY;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready too long");
	property p_idle;
		!PSEL |=> !PREADY;
	endproperty
	a_idle: assert property (p_idle) else $error("ready unasked");
	property p_err;
		PSEL && !PENABLE |=> PSLVERR == !$past(mapped);
	endproperty
	a_err: assert property (p_err) else $error("error flag wrong");
	property p_zero;
		PREADY && (PWRITE || PSLVERR) |-> PRDATA == 32'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("read data not zero");
	property p_oe;
		wr_done && PADDR == `TAU_A_OE && unit_on
			|=> TIMER_OUT_EN == $past(PWDATA[NUM_CH-1:0]);
	endproperty
	a_oe: assert property (p_oe) else $error("enable not written");
	property p_sw;
		wr_done && PADDR == `TAU_A_OUT && unit_on && !TIMER_OUT_EN[1]
			|=> TIMER_OUT[1] == $past(PWDATA[1]);
	endproperty
	a_sw: assert property (p_sw) else $error("sw level lost");
	property p_rst;
		rst_reg && $past(rst_reg, 2) |-> TIMER_OUT_EN == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("enable in reset");
	property p_frz;
		unit_frz && $past(unit_frz, 2) |-> $stable(TIMER_OUT) && $stable(IRQ);
	endproperty
	a_frz: assert property (p_frz) else $error("unit not frozen");
endmodule // tau_chk
bind tau_timer_array tau_chk #(.NUM_CH(NUM_CH)) u_chk (
	.SYS_CLK(SYS_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .TIMER_OUT(TIMER_OUT),
	.TIMER_OUT_EN(TIMER_OUT_EN), .IRQ(IRQ));
`default_nettype wire

// ### tb/timer_array_channel_unit_tb_top.sv
// Purpose: self-checking bench of the timer unit
// Assumes: interval period is (data+1) << prescale
// Notes:   pin 3 drives an event count test
`timescale 1ns/1ps
`default_nettype none
`include "tau_timer_consts.vh"
module timer_array_channel_unit_tb_top;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0;
	logic [31:0] prd;
	logic        prdy;
	logic        perr;
	logic [7:0]  tout;
	logic        irq;
	logic [31:0] rdv;
	logic        o;
	logic        rerr;
	logic [7:0]  tin = 8'h00;
	int          errors = 0;
	int          checks_done = 0;
	int          seed = 57;
	int          d;
	int          n;
	int          pe [4] = '{1, 0, 2, 3};
	int          om [3] = '{8, 9, 12};
	tau_timer_array #(.NUM_CH(8)) dut (.SYS_CLK(clk), .RESETN(rstn),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd),
		.PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .TIMER_IN(tin),
		.TIMER_OUT(tout), .TIMER_OUT_EN(), .IRQ(irq));
	initial forever #4 clk = ~clk;
	initial begin
		#400000;
		errors++;
		conclude();
	end
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] v);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= v;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (prdy !== 1'b1 && k < 16);
		if (prdy !== 1'b1) errors++;
		rdv = prd;
		rerr = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] v);
		apb(1'b1, a, v);
	endtask
	task automatic rd(string nm, logic [11:0] a, logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rdv, e);
	endtask
	function automatic logic [11:0] ra(logic [6:0] r, int ch);
		return {r, 5'h00} + 12'(ch * 4);
	endfunction
	// cycles until the pin level changes
	task automatic gap(int ch, output int c);
		c = 1;
		@(negedge clk);
		o = tout[ch];
		while (tout[ch] === o && c < 5000) begin
			@(negedge clk);
			c++;
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		rd("rst", `TAU_A_RST, 32'h1);
		rd("gate", `TAU_A_GATE, 32'h0);
		wr(`TAU_A_PRE, 32'h3021);
		rd("pre rst", `TAU_A_PRE, 32'h0);
		wr(`TAU_A_RST, 32'h0);
		wr(`TAU_A_PRE, 32'h3021);
		rd("pre gated", `TAU_A_PRE, 32'h0);
		wr(`TAU_A_GATE, 32'h1);
		wr(`TAU_A_PRE, 32'h3021);
		rd("pre", `TAU_A_PRE, 32'h3021);
		rd("unmapped", 12'h100, 32'h0);
		chk("slverr", 32'(rerr), 32'h1);
		wr(`TAU_A_OE, 32'hFFFF);
		rd("oe", `TAU_A_OE, 32'hFF);
		wr(ra(`TAU_R_MODE, 0), 32'hFFFF);
		rd("mode0", ra(`TAU_R_MODE, 0), 32'hD7CF);
		wr(ra(`TAU_R_MODE, 2), 32'hFFFF);
		rd("mode2", ra(`TAU_R_MODE, 2), 32'hDFCF);
		wr(ra(`TAU_R_MODE, 2), 32'h0);
		wr(`TAU_A_OE, 32'h1);
		$display("test registers done");
		for (int s = 0; s < 4; s++) begin
			d = 1 + {$random(seed)} % 6;
			wr(`TAU_A_STOP, 32'h1);
			wr(ra(`TAU_R_DATA, 0), 32'(d));
			wr(ra(`TAU_R_MODE, 0), 32'((s << 14) | 1));
			wr(`TAU_A_START, 32'h1);
			repeat (3) gap(0, n);
			chk("period", 32'(n), 32'((d + 1) << pe[s]));
		end
		rd("status", `TAU_A_STAT, 32'h1);
		chk("irq masked", 32'(irq), 32'h0);
		wr(`TAU_A_MASK, 32'h1);
		repeat (2) @(negedge clk);
		chk("irq", 32'(irq), 32'h1);
		wr(`TAU_A_STOP, 32'h1);
		wr(`TAU_A_STAT, 32'h1);
		repeat (2) @(negedge clk);
		chk("irq clear", 32'(irq), 32'h0);
		$display("test interval done");
		wr(ra(`TAU_R_DATA, 0), 32'd50);
		for (int b = 0; b < 2; b++) begin
			wr(`TAU_A_STOP, 32'h1);
			wr(`TAU_A_STAT, 32'h1);
			wr(ra(`TAU_R_MODE, 0), 32'(b));
			@(negedge clk);
			n = tout[0];
			wr(`TAU_A_START, 32'h1);
			rd("start irq", `TAU_A_STAT, 32'(b));
			chk("start edge", 32'(tout[0] ^ n[0]), 32'(b));
		end
		for (int m = 0; m < 3; m++) begin
			wr(`TAU_A_STOP, 32'h1);
			wr(ra(`TAU_R_MODE, 0), 32'(om[m]));
			wr(`TAU_A_START, 32'h1);
			wr(`TAU_A_STAT, 32'h1);
			wr(`TAU_A_START, 32'h1);
			rd("retrigger", `TAU_A_STAT, 32'(m == 1));
		end
		wr(`TAU_A_STOP, 32'h1);
		@(negedge clk);
		n = tout[0];
		wr(`TAU_A_OUT, {30'h0, 1'b1, ~n[0]});
		@(negedge clk);
		chk("sw out", 32'(tout[1]), 32'h1);
		chk("timer out", 32'(tout[0]), 32'(n[0]));
		$display("test start done");
		// event counter on pin 3: irq after data plus one rises
		wr(`TAU_A_STAT, 32'hFF);
		d = 1 + {$random(seed)} % 4;
		wr(ra(`TAU_R_DATA, 3), 32'(d));
		wr(ra(`TAU_R_MODE, 3), 32'h1046);
		wr(`TAU_A_START, 32'h8);
		for (int p = 0; p <= d; p++) begin
			if (p == d)
				rd("evt early", `TAU_A_STAT, 32'h0);
			repeat (8) @(posedge clk);
			tin[3] <= 1'b1;
			repeat (8) @(posedge clk);
			tin[3] <= 1'b0;
		end
		repeat (8) @(posedge clk);
		rd("evt count", `TAU_A_STAT, 32'h8);
		wr(`TAU_A_STOP, 32'h8);
		$display("test event done");
		// slave pulse width against master period
		d = 1 + {$random(seed)} % 6;
		wr(`TAU_A_PRE, 32'h0);
		wr(ra(`TAU_R_DATA, 0), 32'h9);
		wr(ra(`TAU_R_DATA, 1), 32'(d));
		wr(ra(`TAU_R_MODE, 0), 32'h1);
		wr(ra(`TAU_R_MODE, 1), 32'h409);
		wr(`TAU_A_OE, 32'h3);
		wr(`TAU_A_START, 32'h3);
		repeat (2) gap(1, n);
		if (tout[1] !== 1'b1) gap(1, n);
		gap(1, n);
		chk("pwm high", 32'(n), 32'(d + 1));
		gap(1, n);
		chk("pwm low", 32'(n), 32'(9 - d));
		wr(`TAU_A_GATE, 32'h0);
		wr(`TAU_A_OE, 32'h0);
		rd("oe frozen", `TAU_A_OE, 32'h3);
		wr(`TAU_A_GATE, 32'h1);
		wr(`TAU_A_RST, 32'h1);
		rd("oe in reset", `TAU_A_OE, 32'h0);
		$display("test pwm and gate done");
		conclude();
	end
endmodule // timer_array_channel_unit_tb_top
`default_nettype wire
